// ===== hw/lmc_mode_ctrl.sv
/*
  Mode, wakeup and transmitter control of a LIN transceiver with a two-entry
  buffer of mode change events. Assumes comparator levels and pins are
  asynchronous to core_clk and that the event sink may stall.
*/
`timescale 1ns/1ps
`default_nettype none
module lmc_mode_ctrl
    import lmc_pkg::*;
#(
    parameter lmc_cnt_type TXD_TIMEOUT_CNT = lmc_cnt_type'(TXD_TIMEOUT_CYC),
    parameter lmc_cnt_type WAKE_CNT        = lmc_cnt_type'(WAKE_CYC),
    parameter lmc_cnt_type SAMPLE_TXD_CNT  = lmc_cnt_type'(SAMPLE_TXD_CYC),
    parameter lmc_cnt_type MODE_CNT        = lmc_cnt_type'(MODE_CYC),
    parameter lmc_cnt_type LP_MODE_CNT     = lmc_cnt_type'(LP_MODE_CYC),
    parameter lmc_cnt_type RESET_CNT       = lmc_cnt_type'(RESET_CYC),
    parameter lmc_cnt_type UV_FILTER_CNT   = lmc_cnt_type'(UV_FILTER_CYC)
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Host pins
    input  wire logic             en_pin,
    input  wire logic             txd_pin,
    output var  logic             rxd,
    output var  logic             reset_out_n,
    // Bus side
    input  wire logic             lin_bus_rx,
    output var  logic             lin_dominant,
    // Supply and protection comparators
    input  wire logic             supply_por_high_level_ok,
    input  wire logic             supply_por_low_level_ok,
    input  wire logic             over_temp,
    input  wire logic             vout_undervoltage,
    input  wire logic             dom_timeout_enable,
    output var  logic             vout_enable,
    // Status
    output var  lmc_op_type       op_mode,
    output var  lmc_lin_mode_type lin_mode,
    output var  logic             dom_timeout,
    // Event stream
    output var  logic             evt_valid,
    output var  lmc_event_type    evt_data,
    input  wire logic             evt_ready,
    output var  logic             evt_lost
);

    lmc_state_type st;
    lmc_state_type next_st;
    lmc_pins_type  pins_in;

    assign pins_in.en          = en_pin;
    assign pins_in.txd         = txd_pin;
    assign pins_in.bus_rx      = lin_bus_rx;
    assign pins_in.por_high_ok = supply_por_high_level_ok;
    assign pins_in.por_low_ok  = supply_por_low_level_ok;
    assign pins_in.over_temp   = over_temp;
    assign pins_in.vout_uv     = vout_undervoltage;
    assign pins_in.timeout_en  = dom_timeout_enable;

    always_comb
    begin
        lmc_pins_type  p;
        lmc_op_type    vol;
        lmc_op_type    forced;
        logic          forced_hit;
        logic          vol_exit_reset;
        logic          uv_fault;
        logic          wake_hit;
        logic          pop;
        logic          full;
        logic          tx_active;
        logic          txd_fall;
        lmc_event_type word;

        next_st        = st;
        p              = st.sync2;
        vol            = st.op;
        forced         = st.op;
        forced_hit     = 1'b0;
        vol_exit_reset = st.exit_to_reset;
        word           = '0;
        uv_fault       = 1'b0;
        wake_hit       = 1'b0;
        pop            = 1'b0;
        full           = 1'b0;
        tx_active      = 1'b0;
        txd_fall       = 1'b0;

        next_st.sync1 = pins_in;
        next_st.sync2 = st.sync1;

        // Short glitches of the comparator are not acted on
        next_st.uv_cnt = p.vout_uv ? sat_inc(st.uv_cnt, UV_FILTER_CNT) : '0;
        uv_fault       = (st.uv_cnt >= UV_FILTER_CNT);

        // Counts in active mode too, so a pattern begun there completes in wakeup
        next_st.wake_cnt = (!p.bus_rx && st.lin_mode != LM_OFF)
                         ? sat_inc(st.wake_cnt, WAKE_CNT) : '0;
        wake_hit = (st.wake_cnt >= WAKE_CNT) && (st.lin_mode == LM_WAKEUP);

        pop  = st.evt_buf_valid[0] && evt_ready;
        full = st.evt_buf_valid[1] && !pop;

        unique case (st.op)
            OP_SHUTDOWN:
            begin
                if (p.por_high_ok && !p.over_temp)
                    vol = OP_RESET;
            end
            OP_RESET:
            begin
                if (st.mode_cnt >= RESET_CNT && !uv_fault)
                    vol = p.en ? OP_NORMAL : OP_STANDBY;
            end
            OP_NORMAL:
            begin
                if (!p.en)
                    vol = OP_LP_ENTRY;
            end
            OP_LP_ENTRY:
            begin
                if (st.mode_cnt >= LP_MODE_CNT)
                    vol = st.lp_to_sleep ? OP_SLEEP : OP_STANDBY;
            end
            OP_STANDBY:
            begin
                if (p.en)
                begin
                    vol            = OP_LP_EXIT;
                    vol_exit_reset = 1'b0;
                end
            end
            OP_SLEEP:
            begin
                if (p.en || wake_hit)
                begin
                    vol            = OP_LP_EXIT;
                    vol_exit_reset = 1'b1;
                end
            end
            OP_LP_EXIT:
            begin
                if (st.mode_cnt >= MODE_CNT)
                    vol = st.exit_to_reset ? OP_RESET : OP_NORMAL;
            end
            OP_THERMAL:
            begin
                if (!p.over_temp)
                    vol = OP_RESET;
            end
        endcase

        if (st.op == OP_LP_ENTRY && st.mode_cnt == SAMPLE_TXD_CNT)
            next_st.lp_to_sleep = !p.txd;

        // Protection transitions never wait for room in the event buffer
        if (!p.por_low_ok)
        begin
            forced     = OP_SHUTDOWN;
            forced_hit = (st.op != OP_SHUTDOWN);
        end
        else if (p.over_temp && st.op != OP_SHUTDOWN)
        begin
            forced     = OP_THERMAL;
            forced_hit = (st.op != OP_THERMAL);
        end
        else if (uv_fault && (st.op == OP_NORMAL || st.op == OP_STANDBY
                 || st.op == OP_LP_ENTRY || (st.op == OP_LP_EXIT && !st.exit_to_reset)))
        begin
            forced     = OP_RESET;
            forced_hit = 1'b1;
        end

        if (forced_hit)
            next_st.op = forced;
        else if (!full)
        begin
            next_st.op            = vol;
            next_st.exit_to_reset = vol_exit_reset;
        end

        next_st.mode_cnt = (next_st.op != st.op) ? '0 : sat_inc(st.mode_cnt, RESET_CNT);

        unique case (next_st.op)
            OP_SHUTDOWN, OP_THERMAL: next_st.lin_mode = LM_OFF;
            OP_NORMAL:               next_st.lin_mode = p.en ? LM_ACTIVE : LM_WAKEUP;
            default:                 next_st.lin_mode = LM_WAKEUP;
        endcase

        next_st.wake_pending = wake_hit
                             || (st.wake_pending && !p.en && next_st.op != OP_SHUTDOWN);

        // Transmitter: enable low gates it off without waiting for the state machine
        tx_active        = (st.lin_mode == LM_ACTIVE) && p.en && (next_st.op == OP_NORMAL);
        txd_fall         = st.txd_prev && !p.txd;
        next_st.txd_prev = p.txd;
        if (st.lin_dominant && p.timeout_en)
            next_st.dom_cnt = sat_inc(st.dom_cnt, TXD_TIMEOUT_CNT);
        else
            next_st.dom_cnt = '0;
        if (p.txd)
            next_st.dom_timeout = 1'b0;
        if (st.dom_cnt >= TXD_TIMEOUT_CNT)
            next_st.dom_timeout = 1'b1;
        if (!tx_active || p.txd || next_st.dom_timeout)
            next_st.lin_dominant = 1'b0;
        else if (txd_fall)
            next_st.lin_dominant = 1'b1;

        unique case (next_st.lin_mode)
            LM_ACTIVE: next_st.rxd = p.bus_rx;
            LM_WAKEUP: next_st.rxd = !next_st.wake_pending;
            default:   next_st.rxd = 1'b1;
        endcase

        next_st.reset_out_n = (next_st.op == OP_NORMAL) || (next_st.op == OP_STANDBY)
                            || (next_st.op == OP_LP_ENTRY)
                            || (next_st.op == OP_LP_EXIT && !next_st.exit_to_reset);
        next_st.vout_enable = (next_st.op != OP_SHUTDOWN) && (next_st.op != OP_SLEEP)
                            && (next_st.op != OP_THERMAL);

        // Head entry always sits in slot 0 so the output comes from a flip-flop
        if (pop)
        begin
            next_st.evt_buf[0]       = st.evt_buf[1];
            next_st.evt_buf_valid[0] = st.evt_buf_valid[1];
            next_st.evt_buf_valid[1] = 1'b0;
        end
        if (next_st.op != st.op)
        begin
            word.op           = next_st.op;
            word.wake_pending = next_st.wake_pending;
            word.dom_timeout  = next_st.dom_timeout;
            if (!next_st.evt_buf_valid[0])
            begin
                next_st.evt_buf[0]       = word;
                next_st.evt_buf_valid[0] = 1'b1;
            end
            else if (!next_st.evt_buf_valid[1])
            begin
                next_st.evt_buf[1]       = word;
                next_st.evt_buf_valid[1] = 1'b1;
            end
            else
                next_st.evt_lost = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            st <= state_rst();
        else
            st <= next_st;
    end

    assign rxd          = st.rxd;
    assign reset_out_n  = st.reset_out_n;
    assign lin_dominant = st.lin_dominant;
    assign vout_enable  = st.vout_enable;
    assign op_mode      = st.op;
    assign lin_mode     = st.lin_mode;
    assign dom_timeout  = st.dom_timeout;
    assign evt_valid    = st.evt_buf_valid[0];
    assign evt_data     = st.evt_buf[0];
    assign evt_lost     = st.evt_lost;

    logic        full_now;
    lmc_cnt_type dom_run;

    assign full_now = st.evt_buf_valid[1] && !(st.evt_buf_valid[0] && evt_ready);

    // Run length kept apart from the design's own counter, so a broken stop is caught
    always_ff @(posedge core_clk)
    begin
        if (!nrst || !lin_dominant || !st.sync2.timeout_en)
            dom_run <= '0;
        else
            dom_run <= dom_run + 1'b1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_dom_time_limit: assert property (lin_dominant |-> dom_run <= TXD_TIMEOUT_CNT)
        else $error("dominant held past timeout");
    a_dom_timeout_stop: assert property (st.dom_cnt >= TXD_TIMEOUT_CNT |=> !lin_dominant)
        else $error("dominant not stopped at timeout");
    a_dom_restart: assert property (!lin_dominant |=> st.dom_cnt == '0)
        else $error("dominant timer not restarted");
    a_wake_qualify: assert property ($rose(st.wake_pending) |-> $past(st.wake_cnt) >= WAKE_CNT)
        else $error("wakeup accepted too early");
    a_txd_sample: assert property ((st.op == OP_LP_ENTRY && st.mode_cnt == SAMPLE_TXD_CNT)
        |=> st.lp_to_sleep == !$past(st.sync2.txd))
        else $error("TxD sample wrong");
    a_exit_time: assert property ((op_mode == OP_NORMAL && $past(op_mode) == OP_LP_EXIT)
        |-> $past(st.mode_cnt) >= MODE_CNT)
        else $error("low power exit too fast");
    a_lp_settle: assert property ((op_mode == OP_SLEEP && $past(op_mode) == OP_LP_ENTRY)
        |-> $past(st.mode_cnt) >= LP_MODE_CNT)
        else $error("low power entry too fast");
    a_uv_filter: assert property ((op_mode == OP_RESET && $past(op_mode) == OP_NORMAL)
        |-> $past(st.uv_cnt) >= UV_FILTER_CNT)
        else $error("undervoltage acted on too early");
    a_shutdown_off: assert property (op_mode == OP_SHUTDOWN |-> !vout_enable && !reset_out_n)
        else $error("shutdown left regulator or reset active");
    a_active_enable: assert property (lin_mode == LM_ACTIVE
        |-> op_mode == OP_NORMAL && $past(st.sync2.en))
        else $error("active mode without enable");
    a_lp_wakeup: assert property ((op_mode == OP_LP_ENTRY || op_mode == OP_STANDBY)
        |-> lin_mode == LM_WAKEUP && !lin_dominant)
        else $error("transmitter live with enable low");
    a_tx_enable_off: assert property ((st.op == OP_NORMAL && !st.sync2.en) |=> !lin_dominant)
        else $error("transmitter not disabled on enable fall");
    a_dom_edge_start: assert property ($rose(lin_dominant)
        |-> $past(st.txd_prev) && !$past(st.sync2.txd))
        else $error("dominant without TxD falling edge");
    a_rxd_wake_hold: assert property ((st.wake_pending && lin_mode == LM_WAKEUP) |-> !rxd)
        else $error("receive not held low after wakeup");
    a_off_quiet: assert property (lin_mode == LM_OFF |-> rxd && !lin_dominant)
        else $error("off mode not quiet");
    a_off_protect: assert property ((op_mode == OP_SHUTDOWN || op_mode == OP_THERMAL)
        |-> lin_mode == LM_OFF)
        else $error("transceiver not off in shutdown");
    a_sleep_wakeup: assert property (op_mode == OP_SLEEP |-> lin_mode == LM_WAKEUP)
        else $error("sleep without wakeup mode");
    a_reset_release: assert property ($rose(reset_out_n) && $past(op_mode) == OP_RESET
        |-> (op_mode == OP_NORMAL || op_mode == OP_STANDBY) && $past(st.mode_cnt) >= RESET_CNT)
        else $error("reset released wrongly");
    a_reset_low: assert property (op_mode == OP_RESET |-> !reset_out_n)
        else $error("reset output released during reset mode");
    // Protection changes take priority over the enable request
    a_sleep_leave: assert property ((st.op == OP_SLEEP && st.sync2.en && !full_now
        && st.sync2.por_low_ok && !st.sync2.over_temp) |=> op_mode == OP_LP_EXIT)
        else $error("sleep not left on enable");

    c_wake_seen:    cover property ($rose(st.wake_pending));
    c_timeout_seen: cover property ($rose(dom_timeout));
    c_sleep_entry:  cover property (op_mode == OP_LP_ENTRY ##1 op_mode == OP_SLEEP);
    c_normal_entry: cover property (op_mode == OP_RESET ##1 op_mode == OP_NORMAL);
    c_stby_entry:   cover property (op_mode == OP_LP_ENTRY ##1 op_mode == OP_STANDBY);

endmodule
`default_nettype wire

// ===== hw/lmc_pkg.sv
/*
  Shared constants, timing counts and types of the LIN transceiver mode control.
  Assumes a single 200 MHz core clock and comparator levels from the analog side.
*/
package lmc_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int CNT_W         = 22;

    // Least times, rounded up to whole cycles
    localparam int T_TXD_TIMEOUT_MS                  = 9;
    localparam int T_WAKE_DOMINANT_US                = 30;
    localparam int T_SAMPLE_TXD_US                   = 13;
    localparam int T_MODE_US                         = 13;
    localparam int T_LOW_POWER_TRANSITION_TIME_US    = 27;
    localparam int T_RESET_PULSE_MS                  = 3;
    localparam int T_UV_FILTER_US                    = 13;

    localparam int TXD_TIMEOUT_CYC = (T_TXD_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int WAKE_CYC        = (T_WAKE_DOMINANT_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int SAMPLE_TXD_CYC  = (T_SAMPLE_TXD_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int MODE_CYC        = (T_MODE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LP_MODE_CYC     = (T_LOW_POWER_TRANSITION_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int RESET_CYC       = (T_RESET_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int UV_FILTER_CYC   = (T_UV_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;

    typedef logic [CNT_W-1:0] lmc_cnt_type;

    typedef enum logic [2:0] {
        OP_SHUTDOWN,
        OP_RESET,
        OP_NORMAL,
        OP_STANDBY,
        OP_SLEEP,
        OP_THERMAL,
        OP_LP_ENTRY,
        OP_LP_EXIT
    } lmc_op_type;

    typedef enum logic [1:0] {
        LM_OFF,
        LM_WAKEUP,
        LM_ACTIVE
    } lmc_lin_mode_type;

    typedef struct packed {
        logic en;
        logic txd;
        logic bus_rx;
        logic por_high_ok;
        logic por_low_ok;
        logic over_temp;
        logic vout_uv;
        logic timeout_en;
    } lmc_pins_type;

    typedef struct packed {
        lmc_op_type op;
        logic       wake_pending;
        logic       dom_timeout;
    } lmc_event_type;

    typedef struct packed {
        lmc_pins_type          sync1;
        lmc_pins_type          sync2;
        lmc_op_type            op;
        lmc_lin_mode_type      lin_mode;
        logic                  lp_to_sleep;
        logic                  exit_to_reset;
        lmc_cnt_type           mode_cnt;
        lmc_cnt_type           dom_cnt;
        lmc_cnt_type           wake_cnt;
        lmc_cnt_type           uv_cnt;
        logic                  txd_prev;
        logic                  dom_timeout;
        logic                  lin_dominant;
        logic                  wake_pending;
        logic                  rxd;
        logic                  reset_out_n;
        logic                  vout_enable;
        lmc_event_type [1:0]   evt_buf;
        logic [1:0]            evt_buf_valid;
        logic                  evt_lost;
    } lmc_state_type;

    function automatic lmc_state_type state_rst();
        lmc_state_type s;
        s     = '0;
        s.rxd = 1'b1;
        return s;
    endfunction

    function automatic lmc_cnt_type sat_inc(lmc_cnt_type c, lmc_cnt_type lim);
        return (c >= lim) ? c : c + 1'b1;
    endfunction

endpackage

// ===== sim/lin_transceiver_mode_control_bench.sv
/*
  Self-checking bench of lmc_mode_ctrl; the bench plays host pins and supply
  comparators. Assumes short count parameters to keep the run brief.
*/
`timescale 1ns/1ps
`default_nettype none
module lin_transceiver_mode_control_bench
    import lmc_pkg::*;
;
    localparam int TO = 200;
    localparam int WK = 20;
    localparam int MD = 10;
    localparam int LP = 25;
    localparam int RS = 100;
    localparam int UV = 8;

    logic             core_clk, nrst, en, txd, por_hi, por_lo, hot, uv, to_en;
    logic             remote, stall, rxd, reset_out_n, lin_dominant, lin_bus_rx;
    logic             vout_enable, dom_timeout, evt_valid, evt_ready, evt_lost;
    lmc_op_type       op_mode;
    lmc_lin_mode_type lin_mode;
    lmc_event_type    evt_data;
    int               n_mismatch = 0;
    int               n_compared = 0;
    int               n;

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    lmc_mode_ctrl #(
        .TXD_TIMEOUT_CNT(lmc_cnt_type'(TO)),
        .WAKE_CNT       (lmc_cnt_type'(WK)),
        .SAMPLE_TXD_CNT (lmc_cnt_type'(10)),
        .MODE_CNT       (lmc_cnt_type'(MD)),
        .LP_MODE_CNT    (lmc_cnt_type'(LP)),
        .RESET_CNT      (lmc_cnt_type'(RS)),
        .UV_FILTER_CNT  (lmc_cnt_type'(UV))
    ) u_dut (
        .core_clk(core_clk), .nrst(nrst), .en_pin(en), .txd_pin(txd), .rxd(rxd),
        .reset_out_n(reset_out_n), .lin_bus_rx(lin_bus_rx), .lin_dominant(lin_dominant),
        .supply_por_high_level_ok(por_hi), .supply_por_low_level_ok(por_lo),
        .over_temp(hot), .vout_undervoltage(uv), .dom_timeout_enable(to_en),
        .vout_enable(vout_enable), .op_mode(op_mode), .lin_mode(lin_mode),
        .dom_timeout(dom_timeout), .evt_valid(evt_valid), .evt_data(evt_data),
        .evt_ready(evt_ready), .evt_lost(evt_lost)
    );

    lmc_lin_partner u_p (
        .core_clk(core_clk), .lin_dominant(lin_dominant), .lin_bus_rx(lin_bus_rx),
        .evt_valid(evt_valid), .evt_data(evt_data), .evt_ready(evt_ready),
        .remote_dom(remote), .stall(stall)
    );

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic in_range(string what, int v, int lo, int hi);
        check(what, 32'(v >= lo && v <= hi), 32'h1);
    endtask

    task automatic at_pos();
        @(posedge core_clk);
    endtask

    task automatic wait_n(int k);
        repeat (k) @(negedge core_clk);
    endtask

    // Outputs are looked at on the falling edge, clear of the launch edge
    task automatic wait_op(lmc_op_type t, int lim);
        n = 0;
        while (op_mode !== t)
        begin
            if (n >= lim)
            begin
                check("op wait", 32'(op_mode), 32'(t));
                complete_run();
            end
            wait_n(1);
            n++;
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_power();
        check("op", 32'(op_mode), 32'(OP_SHUTDOWN));
        check("lin_mode", 32'(lin_mode), 32'(LM_OFF));
        check("rxd", 32'(rxd), 32'h1);
        at_pos();
        por_lo <= 1'b1;
        por_hi <= 1'b1;
        en <= 1'b1;
        wait_op(OP_RESET, 10);
        check("vout_enable", 32'(vout_enable), 32'h1);
        wait_n(RS / 2);
        check("reset_out_n", 32'(reset_out_n), 32'h0);
        wait_op(OP_NORMAL, RS);
        in_range("reset time", n + RS / 2, RS, RS + 3);
        check("reset_out_n", 32'(reset_out_n), 32'h1);
        check("lin_mode", 32'(lin_mode), 32'(LM_ACTIVE));
        $display("test power done");
    endtask

    task automatic t_tx();
        at_pos();
        txd <= 1'b0;
        wait_n(7);
        check("lin_dominant", 32'(lin_dominant), 32'h1);
        check("rxd", 32'(rxd), 32'h0);
        at_pos();
        txd <= 1'b1;
        wait_n(7);
        check("lin_dominant", 32'(lin_dominant), 32'h0);
        check("rxd", 32'(rxd), 32'h1);
        at_pos();
        txd <= 1'b0;
        wait_n(4);
        for (n = 0; dom_timeout !== 1'b1 && n < TO + 10; n++)
            wait_n(1);
        in_range("timeout", n, TO - 2, TO + 3);
        if (n >= TO + 10)
            complete_run();
        check("lin_dominant", 32'(lin_dominant), 32'h0);
        at_pos();
        txd <= 1'b1;
        wait_n(4);
        check("dom_timeout", 32'(dom_timeout), 32'h0);
        at_pos();
        txd <= 1'b0;
        wait_n(4);
        check("lin_dominant", 32'(lin_dominant), 32'h1);
        at_pos();
        txd <= 1'b1;
        to_en <= 1'b0;
        wait_n(4);
        at_pos();
        txd <= 1'b0;
        wait_n(TO + 20);
        check("lin_dominant", 32'(lin_dominant), 32'h1);
        at_pos();
        txd <= 1'b1;
        to_en <= 1'b1;
        wait_n(4);
        $display("test transmit done");
    endtask

    task automatic t_standby();
        at_pos();
        txd <= 1'b0;
        wait_n(4);
        at_pos();
        en <= 1'b0;
        wait_n(4);
        check("lin_dominant", 32'(lin_dominant), 32'h0);
        check("lin_mode", 32'(lin_mode), 32'(LM_WAKEUP));
        at_pos();
        txd <= 1'b1;
        wait_op(OP_STANDBY, LP + 5);
        in_range("lp time", n, LP - 2, LP + 2);
        at_pos();
        remote <= 1'b1;
        repeat (WK - 6) at_pos();
        remote <= 1'b0;
        wait_n(5);
        check("rxd", 32'(rxd), 32'h1);
        at_pos();
        remote <= 1'b1;
        repeat (WK + 6) at_pos();
        remote <= 1'b0;
        wait_n(10);
        check("rxd", 32'(rxd), 32'h0);
        at_pos();
        txd <= 1'b0;
        en <= 1'b1;
        wait_op(OP_LP_EXIT, 10);
        wait_op(OP_NORMAL, MD + 5);
        in_range("mode time", n, MD - 1, MD + 2);
        wait_n(4);
        check("lin_dominant", 32'(lin_dominant), 32'h0);
        check("rxd", 32'(rxd), 32'h1);
        at_pos();
        txd <= 1'b1;
        wait_n(4);
        $display("test standby done");
    endtask

    task automatic t_sleep();
        at_pos();
        en <= 1'b0;
        txd <= 1'b0;
        wait_op(OP_SLEEP, LP + 10);
        check("lin_mode", 32'(lin_mode), 32'(LM_WAKEUP));
        at_pos();
        txd <= 1'b1;
        remote <= 1'b1;
        repeat (WK + 6) at_pos();
        remote <= 1'b0;
        wait_op(OP_RESET, MD + 20);
        check("rxd", 32'(rxd), 32'h0);
        wait_op(OP_STANDBY, RS + 10);
        check("reset_out_n", 32'(reset_out_n), 32'h1);
        at_pos();
        en <= 1'b1;
        wait_op(OP_NORMAL, MD + 20);
        wait_n(4);
        check("rxd", 32'(rxd), 32'h1);
        $display("test sleep done");
    endtask

    // Wake dominant starts in active mode and completes in wakeup mode
    task automatic t_span();
        at_pos();
        remote <= 1'b1;
        repeat (10) at_pos();
        en <= 1'b0;
        repeat (WK) at_pos();
        remote <= 1'b0;
        wait_n(4);
        check("rxd", 32'(rxd), 32'h0);
        wait_op(OP_STANDBY, LP + 10);
        at_pos();
        en <= 1'b1;
        wait_op(OP_NORMAL, MD + 20);
        $display("test span done");
    endtask

    task automatic t_events();
        lmc_op_type exp_ops[4] = '{OP_LP_ENTRY, OP_STANDBY, OP_LP_EXIT, OP_NORMAL};
        at_pos();
        stall <= 1'b1;
        en <= 1'b0;
        wait_op(OP_STANDBY, LP + 10);
        // Cleared once the stall holds, so the last word of the span test is not counted
        u_p.seen_ops.delete();
        at_pos();
        en <= 1'b1;
        wait_n(40);
        check("held op", 32'(op_mode), 32'(OP_STANDBY));
        check("evt_valid", 32'(evt_valid), 32'h1);
        at_pos();
        stall <= 1'b0;
        wait_op(OP_NORMAL, MD + 20);
        wait_n(4);
        check("events", 32'(u_p.seen_ops.size()), 32'h4);
        foreach (exp_ops[i])
            check("event op", 32'(u_p.seen_ops[i]), 32'(exp_ops[i]));
        check("evt_valid", 32'(evt_valid), 32'h0);
        check("evt_lost", 32'(evt_lost), 32'h0);
        $display("test events done");
    endtask

    task automatic t_uv();
        at_pos();
        uv <= 1'b1;
        repeat (UV - 4) at_pos();
        uv <= 1'b0;
        wait_n(6);
        check("op", 32'(op_mode), 32'(OP_NORMAL));
        at_pos();
        uv <= 1'b1;
        wait_op(OP_RESET, UV + 10);
        in_range("uv filter", n, UV, UV + 5);
        check("reset_out_n", 32'(reset_out_n), 32'h0);
        at_pos();
        uv <= 1'b0;
        wait_op(OP_NORMAL, RS + 20);
        $display("test undervoltage done");
    endtask

    task automatic t_heat_down();
        at_pos();
        hot <= 1'b1;
        wait_op(OP_THERMAL, 10);
        check("lin_mode", 32'(lin_mode), 32'(LM_OFF));
        at_pos();
        txd <= 1'b0;
        wait_n(6);
        check("lin_dominant", 32'(lin_dominant), 32'h0);
        check("rxd", 32'(rxd), 32'h1);
        at_pos();
        txd <= 1'b1;
        hot <= 1'b0;
        wait_op(OP_RESET, 10);
        wait_op(OP_NORMAL, RS + 20);
        at_pos();
        por_lo <= 1'b0;
        por_hi <= 1'b0;
        wait_op(OP_SHUTDOWN, 10);
        check("lin_mode", 32'(lin_mode), 32'(LM_OFF));
        check("vout_enable", 32'(vout_enable), 32'h0);
        $display("test thermal and shutdown done");
    endtask

    initial
    begin
        nrst = 1'b0;
        en = 1'b0;
        txd = 1'b1;
        por_hi = 1'b0;
        por_lo = 1'b0;
        hot = 1'b0;
        uv = 1'b0;
        to_en = 1'b1;
        remote = 1'b0;
        stall = 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        wait_n(5);
        t_power();
        t_tx();
        t_standby();
        t_sleep();
        t_span();
        t_events();
        t_uv();
        t_heat_down();
        complete_run();
    end
endmodule
`default_nettype wire

// ===== sim/lmc_lin_partner.sv
/*
  Far side of the mode control: the wired bus with its remote nodes and the
  event sink. Assumes the bench drives remote_dom and stall at clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module lmc_lin_partner
    import lmc_pkg::*;
(
    // Clock
    input  wire logic          core_clk,
    // Device side
    input  wire logic          lin_dominant,
    output var  logic          lin_bus_rx,
    input  wire logic          evt_valid,
    input  wire lmc_event_type evt_data,
    output var  logic          evt_ready,
    // Scenario control
    input  wire logic          remote_dom,
    input  wire logic          stall
);
    lmc_op_type seen_ops[$];

    // Wired-AND bus: the pull-up gives recessive unless any node pulls low
    assign lin_bus_rx = !(lin_dominant || remote_dom);
    // A slow sink lets the device buffer fill and stall voluntary changes
    assign evt_ready = !stall;

    always @(posedge core_clk)
        if (evt_valid && evt_ready)
            seen_ops.push_back(evt_data.op);
endmodule
`default_nettype wire
